// [sim/ctd_chk.sv]
/*
  ctd_chk: port assertions for ctd_timer.
  assumes every bus write enables all byte lanes.
*/
`timescale 1ns/1ps
module ctd_chk (
  input wire logic clk,
  input wire logic srst,
  input wire ctd_pkg::ctd_wb_req_s wb_req,
  input wire ctd_pkg::ctd_wb_rsp_s wb_rsp,
  input wire logic [1:0] event_in,
  input wire logic wave_out_first,
  input wire logic wave_out_second
);
  import ctd_pkg::*;
  // ==========================================================
  // shadow of written configuration
  logic wr;
  logic off;
  logic dual;
  logic [7:0] cfg;
  logic [1:0] dsel;
  logic [13:0] lim;
  logic [13:0] since;
  assign wr = wb_req.cyc & wb_req.stb & wb_req.we & wb_rsp.ack;
  assign off = !wave_out_first && !wave_out_second;
  always_ff @(posedge clk) begin
    if (srst) begin
      dual <= 1'h0;
      cfg <= 8'h00;
      dsel <= 2'h0;
      lim <= 14'h0002;
      since <= 14'h0000;
    end else begin
      if (wr && wb_req.adr == CTD_REG_CTRL) dual <= wb_req.dat[CTD_CTRL_DUAL];
      if (wr && wb_req.adr == CTD_REG_EVCFG_A) cfg <= wb_req.dat[7:0];
      if (wr && wb_req.adr == CTD_REG_DLY_CFG) dsel <= wb_req.dat[1:0];
      if (wr && wb_req.adr == CTD_REG_CMP_B_FALL) lim <= {1'h0, wb_req.dat[11:0], 1'h0} + 14'h0002;
      if (wr && wb_req.adr == CTD_REG_CTRL) since <= 14'h0000;
      else if (since != 14'h3FFF) since <= since + 14'h0001;
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_ev_a(logic [3:0] m, logic [1:0] fa);
    cfg[0] && cfg[7:4] == m && cfg[3:2] == fa && dsel != CTD_DSEL_BLANK && event_in[0];
  endsequence
  sequence s_m7_rel;
    s_ev_a(CTD_MODE_SW_WAIT, 2'h0) [*3] ##1 !event_in[0];
  endsequence

  property p_ack_wait; wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack; endproperty
  property p_ack_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  property p_dat_idle; !wb_rsp.ack |-> wb_rsp.dat == 32'h0000_0000; endproperty
  property p_unmapped;
    wb_rsp.ack && !wb_req.we && wb_req.adr > CTD_REG_CAPT_B |-> wb_rsp.dat == 32'h0000_0000;
  endproperty
  property p_no_overlap; !dual [*3] |-> !(wave_out_first && wave_out_second); endproperty
  property p_dual_start; dual && since > 14'h0001 && since < lim |-> !wave_out_first; endproperty
  property p_sync_stop; s_ev_a(CTD_MODE_STOP_ALL, 2'h0) [*3] |=> off; endproperty
  property p_unsynced_override_enable_stop; s_ev_a(CTD_MODE_STOP_ALL, 2'h2) [*2] |=> off; endproperty
  property p_m1_stop; s_ev_a(CTD_MODE_JUMP_WAIT, 2'h0) [*3] |=> !wave_out_first; endproperty
  property p_m7_hold; s_m7_rel |=> off [*8]; endproperty

  a_ack_wait: assert property (p_ack_wait) else $error("ack missing after wait state");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero without ack");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_no_overlap: assert property (p_no_overlap) else $error("outputs overlap");
  a_dual_start: assert property (p_dual_start) else $error("first output early");
  a_sync_stop: assert property (p_sync_stop) else $error("synced stop late");
  a_unsynced_override_enable_stop: assert property (p_unsynced_override_enable_stop) else $error("unsynced stop late");
  a_m1_stop: assert property (p_m1_stop) else $error("mode 1 output not stopped");
  a_m7_hold: assert property (p_m7_hold) else $error("mode 7 resumed alone");
endmodule : ctd_chk

bind ctd_timer ctd_chk i_chk (.clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .event_in(event_in), .wave_out_first(wave_out_first), .wave_out_second(wave_out_second));

// [sim/ctd_evt_src.sv]
/*
  ctd_evt_src: event routing model that drives both event inputs.
  assumes bench calls its tasks from one process per input.
*/
`timescale 1ns/1ps
module ctd_evt_src (
  input wire logic clk,
  output logic [1:0] event_in
);
  // ==========================================================
  // level and pulse train drivers
  initial event_in = 2'h0;

  task automatic hold(input int idx, input logic lvl);
    @(posedge clk);
    event_in[idx] <= lvl;
  endtask : hold

  // short pulses are what a noisy source looks like
  task automatic train(input int idx, input int hi, input int lo, input int cnt);
    repeat (cnt) begin
      hold(idx, 1'h1);
      repeat (hi - 1) @(posedge clk);
      hold(idx, 1'h0);
      repeat (lo - 1) @(posedge clk);
    end
  endtask : train
endmodule : ctd_evt_src

// [sim/ctd_timer_tb.sv]
/*
  ctd_timer_tb: register-level tests of the waveform timer.
  assumes ctd_evt_src drives the event inputs.
*/
`timescale 1ns/1ps
module ctd_timer_tb;
  import ctd_pkg::*;
  logic clk;
  logic srst;
  ctd_wb_req_s req;
  ctd_wb_rsp_s rsp;
  logic [1:0] ev;
  logic w1;
  logic w2;
  logic [1:0] wv;
  logic [31:0] q;
  int err_total;
  int check_count;
  int hi;
  int per;
  int n;
  int ar[2] = '{3, 7};
  int af[2] = '{5, 1};
  int br[2] = '{2, 6};
  int bf[2] = '{4, 2};
  assign wv = {w2, w1};

  ctd_timer i_dut (.clk(clk), .srst(srst), .wb_req(req), .wb_rsp(rsp), .event_in(ev),
    .wave_out_first(w1), .wave_out_second(w2));
  ctd_evt_src i_evt (.clk(clk), .event_in(ev));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // bus, measurement and compare tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    req <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge clk);
      c++;
    end while (rsp.ack !== 1'h1 && c < 40);
    q = rsp.dat;
    if (c >= 40) begin
      err_total++;
      report_and_stop();
    end
    req <= '0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input int d);
    xfer(1'h1, a, 32'(d));
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'h0, a, 32'h0000_0000);
  endtask : rd

  task automatic wait_lvl(input int k, input logic lvl, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (wv[k] !== lvl && c < 3000);
    // a missing edge must never pass as a long count
    if (c >= 3000) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_lvl

  task automatic shape(input int k, output int h, output int p);
    int c;
    wait_lvl(k, 1'h0, c);
    wait_lvl(k, 1'h1, c);
    wait_lvl(k, 1'h0, h);
    wait_lvl(k, 1'h1, c);
    p = h + c;
  endtask : shape

  task automatic highs(input int cyc, output int h);
    h = 0;
    repeat (cyc) begin
      @(posedge clk);
      h += int'(wv !== 2'h0);
    end
  endtask : highs

  task automatic setup(input int c, input int a0, input int a1, input int b0, input int b1);
    wr(CTD_REG_CTRL, 0);
    wr(CTD_REG_EVCFG_A, 0);
    wr(CTD_REG_EVCFG_B, 0);
    wr(CTD_REG_CMP_A_RISE, a0);
    wr(CTD_REG_CMP_A_FALL, a1);
    wr(CTD_REG_CMP_B_RISE, b0);
    wr(CTD_REG_CMP_B_FALL, b1);
    wr(CTD_REG_CTRL, c);
  endtask : setup

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // watchdog, sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    srst = 1'h1;
    req = '0;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    chk("wave_reset", 32'h0000_0000, 32'(wv));
    rd(CTD_REG_STATUS);
    chk("status_reset", 32'h0000_0000, q);
    wr(8'h3C, 32'h0000_ABCD);
    rd(8'h3C);
    chk("unmapped", 32'h0000_0000, q);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      setup(1, ar[i], af[i], br[i], bf[i]);
      shape(0, hi, per);
      chk("first_high", af[i] + 1, hi);
      chk("period", ar[i] + af[i] + br[i] + bf[i] + 4, per);
      shape(1, hi, per);
      chk("second_high", bf[i] + 1, hi);
    end
    $display("test four ramp done");
    // dual-slope runs with no input mode configured
    setup(3, 4, 2, 6, 9);
    wait_lvl(0, 1'h1, n);
    chk("dual_first_delay", 1, n >= 20);
    shape(0, hi, per);
    chk("dual_period", 20, per);
    chk("dual_first_high", 11, hi);
    shape(1, hi, per);
    chk("dual_second_high", 13, hi);
    wr(CTD_REG_CMP_A_FALL, 7);
    shape(0, hi, per);
    chk("a_fall_ignored", 11, hi);
    $display("test dual slope done");
    // only plain, unsynced_override_enable-only or filter-only configs are used
    setup(1, 3, 5, 2, 4);
    wr(CTD_REG_EVCFG_A, 8'h40);
    i_evt.hold(0, 1'h1);
    highs(40, n);
    chk("disabled_input", 1, n > 0);
    wr(CTD_REG_EVCFG_A, 8'h41);
    repeat (4) @(posedge clk);
    highs(40, n);
    chk("stop_all_a", 0, n);
    i_evt.hold(0, 1'h0);
    wr(CTD_REG_EVCFG_A, 8'h49);
    i_evt.hold(0, 1'h1);
    repeat (3) @(posedge clk);
    highs(30, n);
    chk("unsynced_stop", 0, n);
    i_evt.hold(0, 1'h0);
    wr(CTD_REG_EVCFG_A, 8'h45);
    // let the filter settle low so no stale level clips the pulse
    repeat (8) @(posedge clk);
    fork
      i_evt.train(0, 3, 3, 14);
      shape(0, hi, per);
    join
    chk("filter_drop", 6, hi);
    i_evt.hold(0, 1'h1);
    repeat (10) @(posedge clk);
    highs(30, n);
    chk("filter_pass", 0, n);
    i_evt.hold(0, 1'h0);
    $display("test event inputs done");
    // blanking only, delayed output event left off
    setup(1, 3, 5, 2, 4);
    wr(CTD_REG_DLY_CFG, 1);
    wr(CTD_REG_DLY_LIMIT, 200);
    wr(CTD_REG_EVCFG_A, 8'h41);
    wr(CTD_REG_EVCFG_B, 8'h41);
    wait_lvl(0, 1'h1, n);
    i_evt.hold(0, 1'h1);
    highs(40, n);
    chk("blank_a", 1, n > 0);
    i_evt.hold(1, 1'h1);
    repeat (4) @(posedge clk);
    highs(30, n);
    chk("no_blank_b", 0, n);
    i_evt.hold(1, 1'h0);
    i_evt.hold(0, 1'h0);
    wr(CTD_REG_DLY_CFG, 0);
    i_evt.hold(0, 1'h1);
    repeat (4) @(posedge clk);
    highs(30, n);
    chk("blank_off", 0, n);
    i_evt.hold(0, 1'h0);
    $display("test blanking done");
    setup(1, 3, 5, 2, 4);
    wr(CTD_REG_EVCFG_A, 8'h11);
    wait_lvl(0, 1'h1, n);
    i_evt.hold(0, 1'h1);
    repeat (4) @(posedge clk);
    rd(CTD_REG_STATUS);
    chk("m1a_phase", 32'(CTD_DEAD_SECOND), q[13:12]);
    chk("m1a_held", 1, q[CTD_ST_STOP]);
    highs(20, n);
    chk("m1a_outputs", 0, n);
    i_evt.hold(0, 1'h0);
    wait_lvl(1, 1'h1, n);
    chk("m1a_resume", 1, n <= 12);
    wr(CTD_REG_EVCFG_A, 0);
    wr(CTD_REG_EVCFG_B, 8'h11);
    wait_lvl(1, 1'h1, n);
    i_evt.hold(1, 1'h1);
    repeat (4) @(posedge clk);
    rd(CTD_REG_STATUS);
    chk("m1b_phase", 32'(CTD_DEAD_FIRST), q[13:12]);
    chk("m1b_held", 1, q[CTD_ST_STOP]);
    i_evt.hold(1, 1'h0);
    wait_lvl(0, 1'h1, n);
    chk("m1b_resume", 1, n <= 12);
    wr(CTD_REG_EVCFG_B, 0);
    wr(CTD_REG_EVCFG_A, 8'h71);
    i_evt.hold(0, 1'h1);
    repeat (4) @(posedge clk);
    i_evt.hold(0, 1'h0);
    highs(40, n);
    chk("m7_stopped", 0, n);
    rd(CTD_REG_STATUS);
    chk("m7_held", 1, q[CTD_ST_STOP]);
    wr(CTD_REG_CTRL, 5);
    wait_lvl(0, 1'h1, n);
    chk("m7_restart", 1, n <= 8);
    $display("test input modes done");
    setup(1, 3, 5, 2, 4);
    for (int m = 0; m < 16; m++) begin
      if (m != 1 && m != 4 && m != 7) begin
        wr(CTD_REG_EVCFG_A, m * 16 + 1);
        i_evt.hold(0, 1'h1);
        highs(40, n);
        chk("no_action_mode", 1, n > 0);
        i_evt.hold(0, 1'h0);
      end
    end
    $display("test reserved modes done");
    // disabled dual-slope parks the counter at compare_b_fall
    wr(CTD_REG_CTRL, 2);
    wr(CTD_REG_EVCFG_A, 8'h03);
    wr(CTD_REG_EVCFG_B, 8'h03);
    i_evt.hold(0, 1'h1);
    i_evt.hold(1, 1'h1);
    repeat (4) @(posedge clk);
    rd(CTD_REG_CAPT_A);
    chk("capture_a", 4, q);
    rd(CTD_REG_CAPT_B);
    chk("capture_b", 4, q);
    i_evt.hold(0, 1'h0);
    i_evt.hold(1, 1'h0);
    $display("test capture done");
    report_and_stop();
  end
endmodule : ctd_timer_tb

// [verilog/ctd_pkg.sv]
/*
  ctd_pkg: constants, register map, field layouts and state types for the
  four-ramp / dual-slope waveform timer with two event inputs.
  assumes one 200 MHz clock drives counter, synchroniser and delay logic.
*/
package ctd_pkg;

  // ==========================================================================
  // widths
  localparam int CTD_CNT_W = 12;
  localparam int CTD_DW = 32;
  localparam int CTD_AW = 8;
  localparam int CTD_DLY_W = 8;
  localparam int CTD_PRE_W = 3;
  localparam int CTD_FILT_LEN = 4;

  // ==========================================================================
  // register byte offsets
  localparam logic [CTD_AW-1:0] CTD_REG_CTRL = 8'h00;
  localparam logic [CTD_AW-1:0] CTD_REG_CMP_A_RISE = 8'h04;
  localparam logic [CTD_AW-1:0] CTD_REG_CMP_A_FALL = 8'h08;
  localparam logic [CTD_AW-1:0] CTD_REG_CMP_B_RISE = 8'h0C;
  localparam logic [CTD_AW-1:0] CTD_REG_CMP_B_FALL = 8'h10;
  localparam logic [CTD_AW-1:0] CTD_REG_EVCFG_A = 8'h14;
  localparam logic [CTD_AW-1:0] CTD_REG_EVCFG_B = 8'h18;
  localparam logic [CTD_AW-1:0] CTD_REG_DLY_CFG = 8'h1C;
  localparam logic [CTD_AW-1:0] CTD_REG_DLY_LIMIT = 8'h20;
  localparam logic [CTD_AW-1:0] CTD_REG_STATUS = 8'h24;
  localparam logic [CTD_AW-1:0] CTD_REG_CAPT_A = 8'h28;
  localparam logic [CTD_AW-1:0] CTD_REG_CAPT_B = 8'h2C;

  // ==========================================================================
  // field positions
  localparam int CTD_CTRL_EN = 0;
  localparam int CTD_CTRL_DUAL = 1;
  localparam int CTD_CTRL_RESTART = 2;
  localparam int CTD_EV_LO = 0;
  localparam int CTD_EV_HI = 7;
  localparam int CTD_DSEL_LO = 0;
  localparam int CTD_DTRIG_LO = 2;
  localparam int CTD_DPRE_LO = 4;
  localparam int CTD_ST_PHASE_LO = 12;
  localparam int CTD_ST_WAVE_LO = 14;
  localparam int CTD_ST_BLANK = 16;
  localparam int CTD_ST_EVT_LO = 17;
  localparam int CTD_ST_STOP = 19;

  // ==========================================================================
  // codes and reset values
  localparam logic [3:0] CTD_MODE_JUMP_WAIT = 4'h1;
  localparam logic [3:0] CTD_MODE_STOP_ALL = 4'h4;
  localparam logic [3:0] CTD_MODE_SW_WAIT = 4'h7;
  localparam logic [1:0] CTD_DSEL_BLANK = 2'h1;
  localparam logic [1:0] CTD_TRIG_FIRST_RISE = 2'h0;
  localparam logic [1:0] CTD_TRIG_FIRST_FALL = 2'h1;
  localparam logic [1:0] CTD_TRIG_SECOND_RISE = 2'h2;
  localparam logic [CTD_CNT_W-1:0] CTD_CNT_ZERO = 12'h000;
  localparam logic [CTD_CNT_W-1:0] CTD_CNT_ONE = 12'h001;
  localparam logic [CTD_DLY_W-1:0] CTD_DLY_ONE = 8'h01;
  localparam logic [CTD_PRE_W-1:0] CTD_PRE_ONE = 3'h1;
  localparam logic [CTD_FILT_LEN-1:0] CTD_FILT_HIGH = 4'hF;
  localparam logic [CTD_FILT_LEN-1:0] CTD_FILT_LOW = 4'h0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    CTD_DEAD_FIRST,
    CTD_ON_FIRST,
    CTD_DEAD_SECOND,
    CTD_ON_SECOND
  } ctd_phase_e;

  typedef struct packed {
    logic [3:0] mode;
    logic unsynced_override_enable_en;
    logic filter;
    logic action;
    logic enable;
  } ctd_evcfg_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [CTD_AW-1:0] adr;
    logic [CTD_DW-1:0] dat;
  } ctd_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [CTD_DW-1:0] dat;
  } ctd_wb_rsp_s;

  typedef struct packed {
    logic enable;
    logic dual;
    logic [3:0][CTD_CNT_W-1:0] cmp;
    ctd_evcfg_s [1:0] evcfg;
    logic [1:0] dsel;
    logic [1:0] dtrig;
    logic [1:0] dpre;
    logic [CTD_DLY_W-1:0] dlimit;
    ctd_phase_e phase;
    logic [CTD_CNT_W-1:0] cnt;
    logic down;
    logic first_done;
    logic [1:0] hold;
    logic sw_stop;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] raw_q;
    logic [1:0][CTD_FILT_LEN-1:0] filt_hist;
    logic [1:0] filt_lvl;
    logic [1:0] evt_prev;
    logic blanking;
    logic [CTD_PRE_W-1:0] pre_cnt;
    logic [CTD_DLY_W-1:0] dly_cnt;
    logic wave_first;
    logic wave_second;
    logic out_first;
    logic out_second;
    logic [1:0][CTD_CNT_W-1:0] capture;
    logic ack;
    logic [CTD_DW-1:0] rdat;
  } ctd_state_s;

endpackage : ctd_pkg

// [verilog/ctd_timer.sv]
/*
  ctd_timer: waveform timer core with four-ramp and dual-slope cycles,
  two event inputs with filter, unsynced override and capture, blanking on input A only,
  behind a classic wishbone slave.
  assumes event inputs synchronous to clk; one clock serves as counter,
  synchroniser and delay clock.
*/
`timescale 1ns/1ps

module ctd_timer (
  input wire logic clk,
  input wire logic srst,
  input wire ctd_pkg::ctd_wb_req_s wb_req,
  output ctd_pkg::ctd_wb_rsp_s wb_rsp,
  input wire logic [1:0] event_in,
  output logic wave_out_first,
  output logic wave_out_second
);
  import ctd_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic in_own_phases(input logic idx, input ctd_phase_e ph);
    if (idx == 1'b0) begin
      in_own_phases = (ph == CTD_DEAD_FIRST) || (ph == CTD_ON_FIRST);
    end else begin
      in_own_phases = (ph == CTD_DEAD_SECOND) || (ph == CTD_ON_SECOND);
    end
  endfunction : in_own_phases

  function automatic logic [CTD_PRE_W-1:0] pre_top(input logic [1:0] code);
    pre_top = CTD_PRE_W'((1 << code) - 1);
  endfunction : pre_top

  ctd_state_s s;
  ctd_state_s n;

  logic [1:0] proc;
  logic [1:0] evt;
  logic [1:0] ovr;
  logic wr;
  logic rd;
  logic restart;
  logic run;
  logic kill_first;
  logic kill_second;
  logic trig;
  logic [CTD_DW-1:0] status;

  // ==========================================================================
  // next state
  always_comb begin
    n = s;
    proc = '0;
    evt = '0;
    ovr = '0;
    restart = 1'b0;
    run = 1'b0;
    kill_first = 1'b0;
    kill_second = 1'b0;
    trig = 1'b0;

    // ------------------------------------------------------------------------
    // bus slave: one wait state, ack dropped the cycle after it was given
    n.ack = wb_req.cyc & wb_req.stb & ~s.ack;
    wr = n.ack & wb_req.we;
    rd = n.ack & ~wb_req.we;
    status = '0;
    status[CTD_CNT_W-1:0] = s.cnt;
    status[CTD_ST_PHASE_LO +: 2] = s.phase;
    status[CTD_ST_WAVE_LO] = s.out_first;
    status[CTD_ST_WAVE_LO + 1] = s.out_second;
    status[CTD_ST_BLANK] = s.blanking;
    status[CTD_ST_EVT_LO +: 2] = s.evt_prev;
    status[CTD_ST_STOP] = s.sw_stop | (|s.hold);
    n.rdat = '0;
    if (rd) begin
      unique case (wb_req.adr)
        CTD_REG_CTRL: begin
          n.rdat[CTD_CTRL_EN] = s.enable;
          n.rdat[CTD_CTRL_DUAL] = s.dual;
        end
        CTD_REG_CMP_A_RISE: n.rdat[CTD_CNT_W-1:0] = s.cmp[0];
        CTD_REG_CMP_A_FALL: n.rdat[CTD_CNT_W-1:0] = s.cmp[1];
        CTD_REG_CMP_B_RISE: n.rdat[CTD_CNT_W-1:0] = s.cmp[2];
        CTD_REG_CMP_B_FALL: n.rdat[CTD_CNT_W-1:0] = s.cmp[3];
        CTD_REG_EVCFG_A: n.rdat[CTD_EV_HI:CTD_EV_LO] = s.evcfg[0];
        CTD_REG_EVCFG_B: n.rdat[CTD_EV_HI:CTD_EV_LO] = s.evcfg[1];
        CTD_REG_DLY_CFG: begin
          n.rdat[CTD_DSEL_LO +: 2] = s.dsel;
          n.rdat[CTD_DTRIG_LO +: 2] = s.dtrig;
          n.rdat[CTD_DPRE_LO +: 2] = s.dpre;
        end
        CTD_REG_DLY_LIMIT: n.rdat[CTD_DLY_W-1:0] = s.dlimit;
        CTD_REG_STATUS: n.rdat = status;
        CTD_REG_CAPT_A: n.rdat[CTD_CNT_W-1:0] = s.capture[0];
        CTD_REG_CAPT_B: n.rdat[CTD_CNT_W-1:0] = s.capture[1];
        default: n.rdat = '0;
      endcase
    end
    // writes honour only lane 0 and lane 1; config is at most 12 bits
    if (wr && wb_req.sel[0]) begin
      unique case (wb_req.adr)
        CTD_REG_CTRL: begin
          n.enable = wb_req.dat[CTD_CTRL_EN];
          n.dual = wb_req.dat[CTD_CTRL_DUAL];
          restart = wb_req.dat[CTD_CTRL_RESTART];
        end
        CTD_REG_CMP_A_RISE: n.cmp[0][7:0] = wb_req.dat[7:0];
        CTD_REG_CMP_A_FALL: n.cmp[1][7:0] = wb_req.dat[7:0];
        CTD_REG_CMP_B_RISE: n.cmp[2][7:0] = wb_req.dat[7:0];
        CTD_REG_CMP_B_FALL: n.cmp[3][7:0] = wb_req.dat[7:0];
        CTD_REG_EVCFG_A: n.evcfg[0] = wb_req.dat[CTD_EV_HI:CTD_EV_LO];
        CTD_REG_EVCFG_B: n.evcfg[1] = wb_req.dat[CTD_EV_HI:CTD_EV_LO];
        CTD_REG_DLY_CFG: begin
          n.dsel = wb_req.dat[CTD_DSEL_LO +: 2];
          n.dtrig = wb_req.dat[CTD_DTRIG_LO +: 2];
          n.dpre = wb_req.dat[CTD_DPRE_LO +: 2];
        end
        CTD_REG_DLY_LIMIT: n.dlimit = wb_req.dat[CTD_DLY_W-1:0];
        default: n.dlimit = s.dlimit;
      endcase
    end
    if (wr && wb_req.sel[1]) begin
      unique case (wb_req.adr)
        CTD_REG_CMP_A_RISE: n.cmp[0][CTD_CNT_W-1:8] = wb_req.dat[CTD_CNT_W-1:8];
        CTD_REG_CMP_A_FALL: n.cmp[1][CTD_CNT_W-1:8] = wb_req.dat[CTD_CNT_W-1:8];
        CTD_REG_CMP_B_RISE: n.cmp[2][CTD_CNT_W-1:8] = wb_req.dat[CTD_CNT_W-1:8];
        CTD_REG_CMP_B_FALL: n.cmp[3][CTD_CNT_W-1:8] = wb_req.dat[CTD_CNT_W-1:8];
        default: n.cmp = n.cmp;
      endcase
    end

    // ------------------------------------------------------------------------
    // event input path
    n.sync1 = event_in;
    n.sync2 = s.sync1;
    n.raw_q = event_in;
    for (int i = 0; i < 2; i++) begin
      // level accepted only after four equal samples
      n.filt_hist[i] = {s.filt_hist[i][CTD_FILT_LEN-2:0], s.sync2[i]};
      if (s.filt_hist[i] == CTD_FILT_HIGH) begin
        n.filt_lvl[i] = 1'b1;
      end else if (s.filt_hist[i] == CTD_FILT_LOW) begin
        n.filt_lvl[i] = 1'b0;
      end
      proc[i] = s.evcfg[i].filter ? s.filt_lvl[i] : s.sync2[i];
      evt[i] = s.evcfg[i].enable & proc[i] & ~((i == 0) & s.blanking);
      // unsynced sample drives the override, counter keeps synced evt
      // override path skips the two synchroniser stages
      ovr[i] = s.evcfg[i].enable & ~((i == 0) & s.blanking) &
               (s.evcfg[i].unsynced_override_enable_en ? s.raw_q[i] : proc[i]);
      // capture on rising event when action bit set
      if (s.evcfg[i].action && evt[i] && !s.evt_prev[i]) begin
        n.capture[i] = s.cnt;
      end
    end
    n.evt_prev = evt;

    // ------------------------------------------------------------------------
    // counter flow
    if (!s.enable) begin
      n.phase = CTD_DEAD_FIRST;
      n.cnt = n.dual ? s.cmp[3] : CTD_CNT_ZERO;
      n.down = 1'b1;
      n.first_done = 1'b0;
      n.hold = '0;
      n.sw_stop = 1'b0;
      n.wave_first = 1'b0;
      n.wave_second = 1'b0;
    end else if (restart) begin
      // restart always begins at the first dead time
      n.phase = CTD_DEAD_FIRST;
      n.cnt = s.dual ? s.cmp[3] : CTD_CNT_ZERO;
      n.down = 1'b1;
      n.first_done = 1'b0;
      n.hold = '0;
      n.sw_stop = 1'b0;
      n.wave_first = 1'b0;
      n.wave_second = 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // only modes 1, 4 and 7 touch the counter or outputs here
        if (s.evcfg[i].mode == CTD_MODE_SW_WAIT && evt[i]) begin
          n.sw_stop = 1'b1;
        end
        // hold released when the event goes low
        if (s.hold[i] && !evt[i]) begin
          n.hold[i] = 1'b0;
        end
      end
      run = ~(|s.hold) & ~n.sw_stop;
      if (!s.dual) begin
        // input A in first phases jumps to second dead time
        // input B in second phases jumps to first dead time
        if (s.evcfg[0].mode == CTD_MODE_JUMP_WAIT && evt[0] &&
            in_own_phases(1'b0, s.phase)) begin
          n.phase = CTD_DEAD_SECOND;
          n.cnt = CTD_CNT_ZERO;
          n.hold[0] = 1'b1;
        end else if (s.evcfg[1].mode == CTD_MODE_JUMP_WAIT && evt[1] &&
                     in_own_phases(1'b1, s.phase)) begin
          n.phase = CTD_DEAD_FIRST;
          n.cnt = CTD_CNT_ZERO;
          n.hold[1] = 1'b1;
        end else if (run) begin
          // each ramp ends at the compare of its phase
          if (s.cnt == s.cmp[s.phase]) begin
            n.cnt = CTD_CNT_ZERO;
            n.phase = ctd_phase_e'(s.phase + 2'd1);
          end else begin
            n.cnt = s.cnt + CTD_CNT_ONE;
          end
        end
        // outputs follow exclusive phases, so never overlap
        n.wave_first = (n.phase == CTD_ON_FIRST);
        n.wave_second = (n.phase == CTD_ON_SECOND);
      end else if (run) begin
        // down to zero, then up to compare_b_fall
        // compare_a_fall not read in this branch
        if (s.down) begin
          if (s.cnt == CTD_CNT_ZERO) begin
            n.down = 1'b0;
          end else begin
            n.cnt = s.cnt - CTD_CNT_ONE;
          end
        end else if (s.cnt >= s.cmp[3]) begin
          n.down = 1'b1;
          n.first_done = 1'b1;
        end else begin
          n.cnt = s.cnt + CTD_CNT_ONE;
        end
        // first output set on up-match, cleared on down-match
        // no set before the first cycle completes
        if (!s.down && s.cnt == s.cmp[0] && s.first_done) begin
          n.wave_first = 1'b1;
        end else if (s.down && s.cnt == s.cmp[0]) begin
          n.wave_first = 1'b0;
        end
        // second output set on down-match, cleared on up-match
        if (s.down && s.cnt == s.cmp[2]) begin
          n.wave_second = 1'b1;
        end else if (!s.down && s.cnt == s.cmp[2]) begin
          n.wave_second = 1'b0;
        end
        n.phase = s.down ? CTD_ON_SECOND : CTD_ON_FIRST;
      end
    end

    // ------------------------------------------------------------------------
    // output override
    for (int i = 0; i < 2; i++) begin
      if ((s.evcfg[i].mode == CTD_MODE_STOP_ALL || s.evcfg[i].mode == CTD_MODE_SW_WAIT)
          && ovr[i]) begin
        kill_first = 1'b1;
        kill_second = 1'b1;
      end
    end
    // mode 1 kills only its own output
    if (!s.dual && s.evcfg[0].mode == CTD_MODE_JUMP_WAIT && ovr[0] &&
        (s.hold[0] || in_own_phases(1'b0, s.phase))) begin
      kill_first = 1'b1;
    end
    if (!s.dual && s.evcfg[1].mode == CTD_MODE_JUMP_WAIT && ovr[1] &&
        (s.hold[1] || in_own_phases(1'b1, s.phase))) begin
      kill_second = 1'b1;
    end
    n.out_first = n.wave_first & ~kill_first & ~n.sw_stop;
    n.out_second = n.wave_second & ~kill_second & ~n.sw_stop;

    // ------------------------------------------------------------------------
    // input blanking, shared delay logic
    // trigger picked from output edges
    unique case (s.dtrig)
      CTD_TRIG_FIRST_RISE: trig = n.wave_first & ~s.wave_first;
      CTD_TRIG_FIRST_FALL: trig = ~n.wave_first & s.wave_first;
      CTD_TRIG_SECOND_RISE: trig = n.wave_second & ~s.wave_second;
      default: trig = ~n.wave_second & s.wave_second;
    endcase
    if (s.dsel != CTD_DSEL_BLANK) begin
      n.blanking = 1'b0;
    end else if (trig) begin
      n.blanking = (s.dlimit != '0);
      n.pre_cnt = '0;
      n.dly_cnt = '0;
    end else if (s.blanking) begin
      // divided tick counts up to the limit
      if (s.pre_cnt >= pre_top(s.dpre)) begin
        n.pre_cnt = '0;
        n.dly_cnt = s.dly_cnt + CTD_DLY_ONE;
        if (n.dly_cnt >= s.dlimit) begin
          n.blanking = 1'b0;
        end
      end else begin
        n.pre_cnt = s.pre_cnt + CTD_PRE_ONE;
      end
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign wb_rsp.ack = s.ack;
  assign wb_rsp.dat = s.rdat;
  assign wave_out_first = s.out_first;
  assign wave_out_second = s.out_second;

endmodule : ctd_timer
